/* File: rtl/dicfg_top.sv */
// digital input lines 8..10: polarity, role, latch edge and event flags
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "dicfg_map.svh"

// Functional notes
// R1 - polarity digit: 0 positive, 1 inverted
// R2 - function digit: 0 digital, 1 timing latch
// R3 - latch edge digit: 0 rising, 1 falling
// R4 - edge digit resets to zero, rising
// R5 - software keeps factory digits at zero
// R6 - each input has independent own settings
// R7 - synchronise, apply polarity, pulse on edge
module dicfg_top (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_sys_rst,
  input  wire dicfg_pkg::dicfg_bus_req_t i_bus,
  input  wire logic [2:0]                i_din_pins,
  output logic      [15:0]               o_rdata,
  output logic      [2:0]                o_din_level,
  output logic      [2:0]                o_latch_evt,
  output logic                           o_irq
);

  // one bit out of a setting word
  function automatic logic digit_bit(
    input logic [`DICFG_DATA_W-1:0] val,
    input int unsigned              lsb
  );
    digit_bit = val[lsb];
  endfunction

  // write hit on one register offset
  function automatic logic wr_hit(
    input dicfg_pkg::dicfg_bus_req_t req,
    input logic [`DICFG_ADDR_W-1:0]  ofs
  );
    wr_hit = req.wr && (req.addr == ofs);
  endfunction

  logic [`DICFG_DATA_W-1:0]    input8_polarity_setting_ff;
  logic [`DICFG_DATA_W-1:0]    input8_function_setting_ff;
  logic [`DICFG_DATA_W-1:0]    input9_polarity_setting_ff;
  logic [`DICFG_DATA_W-1:0]    input9_function_setting_ff;
  logic [`DICFG_DATA_W-1:0]    input10_polarity_setting_ff;
  logic [`DICFG_DATA_W-1:0]    input10_function_setting_ff;
  logic [2:0]                  evt_mask_ff;
  logic [2:0]                  evt_status_ff;
  logic [2:0]                  nxt_evt_status;
  logic [2:0]                  sync1_ff;
  logic [2:0]                  sync2_ff;
  logic [2:0]                  raw_prev_ff;
  logic [2:0]                  level_ff;
  logic [2:0]                  nxt_level;
  logic [2:0]                  latch_evt_ff;
  logic [2:0]                  nxt_latch_evt;
  logic                        irq_ff;
  logic [`DICFG_DATA_W-1:0]    rdata_ff;
  logic [`DICFG_DATA_W-1:0]    nxt_rdata;
  dicfg_pkg::dicfg_line_cfg_t  line_cfg [3];

  // configuration words, each input kept in its own pair of words
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      input8_polarity_setting_ff <= `DICFG_CFG_RST; // R1
    end else if (wr_hit(i_bus, `DICFG_OFS_IN8_POL)) begin
      input8_polarity_setting_ff <= i_bus.wdata; // R6
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      input8_function_setting_ff <= `DICFG_CFG_RST; // R4
    end else if (wr_hit(i_bus, `DICFG_OFS_IN8_FUNC)) begin
      input8_function_setting_ff <= i_bus.wdata; // R6
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      input9_polarity_setting_ff <= `DICFG_CFG_RST; // R1
    end else if (wr_hit(i_bus, `DICFG_OFS_IN9_POL)) begin
      input9_polarity_setting_ff <= i_bus.wdata; // R6
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      input9_function_setting_ff <= `DICFG_CFG_RST; // R4
    end else if (wr_hit(i_bus, `DICFG_OFS_IN9_FUNC)) begin
      input9_function_setting_ff <= i_bus.wdata; // R6
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      input10_polarity_setting_ff <= `DICFG_CFG_RST; // R1
    end else if (wr_hit(i_bus, `DICFG_OFS_IN10_POL)) begin
      input10_polarity_setting_ff <= i_bus.wdata; // R6
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      input10_function_setting_ff <= `DICFG_CFG_RST; // R4
    end else if (wr_hit(i_bus, `DICFG_OFS_IN10_FUNC)) begin
      input10_function_setting_ff <= i_bus.wdata; // R6
    end
  end

  // decode the digits; factory digits are stored but steer nothing,
  // software is expected to leave them at zero
  always_comb begin
    line_cfg[`DICFG_IDX_IN8].invert =
      digit_bit(input8_polarity_setting_ff, `DICFG_POL_LSB); // R1
    line_cfg[`DICFG_IDX_IN8].func = dicfg_pkg::dicfg_func_t'(
      digit_bit(input8_function_setting_ff, `DICFG_FUNC_LSB)); // R2
    line_cfg[`DICFG_IDX_IN8].edge_sel = dicfg_pkg::dicfg_edge_t'(
      digit_bit(input8_function_setting_ff, `DICFG_EDGE_LSB)); // R3
    line_cfg[`DICFG_IDX_IN9].invert =
      digit_bit(input9_polarity_setting_ff, `DICFG_POL_LSB); // R1
    line_cfg[`DICFG_IDX_IN9].func = dicfg_pkg::dicfg_func_t'(
      digit_bit(input9_function_setting_ff, `DICFG_FUNC_LSB)); // R2
    line_cfg[`DICFG_IDX_IN9].edge_sel = dicfg_pkg::dicfg_edge_t'(
      digit_bit(input9_function_setting_ff, `DICFG_EDGE_LSB)); // R3
    line_cfg[`DICFG_IDX_IN10].invert =
      digit_bit(input10_polarity_setting_ff, `DICFG_POL_LSB); // R1
    line_cfg[`DICFG_IDX_IN10].func = dicfg_pkg::dicfg_func_t'(
      digit_bit(input10_function_setting_ff, `DICFG_FUNC_LSB)); // R2
    line_cfg[`DICFG_IDX_IN10].edge_sel = dicfg_pkg::dicfg_edge_t'(
      digit_bit(input10_function_setting_ff, `DICFG_EDGE_LSB)); // R3
  end

  // two-stage synchroniser on the field pins
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sync1_ff <= `DICFG_VEC_RST;
      sync2_ff <= `DICFG_VEC_RST;
    end else begin
      sync1_ff <= i_din_pins; // R7
      sync2_ff <= sync1_ff; // R7
    end
  end

  // history is kept before the polarity stage, so flipping the
  // polarity digit never looks like an edge on the line
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      raw_prev_ff <= `DICFG_VEC_RST;
    end else begin
      raw_prev_ff <= sync2_ff;
    end
  end

  always_comb begin
    logic cur;
    logic prv;
    cur = 1'b0;
    prv = 1'b0;
    nxt_level = `DICFG_VEC_RST;
    nxt_latch_evt = `DICFG_VEC_RST;
    for (int i = 0; i < `DICFG_NUM_LINES; i++) begin
      cur = sync2_ff[i] ^ line_cfg[i].invert; // R1 R7
      prv = raw_prev_ff[i] ^ line_cfg[i].invert;
      case (line_cfg[i].func)
        dicfg_pkg::DICFG_FUNC_DIGITAL: begin
          nxt_level[i] = cur; // R2
        end
        dicfg_pkg::DICFG_FUNC_LATCH: begin
          case (line_cfg[i].edge_sel)
            dicfg_pkg::DICFG_EDGE_RISE: begin
              nxt_latch_evt[i] = cur & ~prv; // R3 R7
            end
            dicfg_pkg::DICFG_EDGE_FALL: begin
              nxt_latch_evt[i] = ~cur & prv; // R3 R7
            end
            default: begin
              nxt_latch_evt[i] = 1'b0;
            end
          endcase
        end
        default: begin
          nxt_level[i] = 1'b0;
        end
      endcase
    end
  end

  // a latch line drives no level, a digital line raises no events
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      level_ff <= `DICFG_VEC_RST;
    end else begin
      level_ff <= nxt_level; // R2
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      latch_evt_ff <= `DICFG_VEC_RST;
    end else begin
      latch_evt_ff <= nxt_latch_evt; // R7
    end
  end

  // sticky event flags, write one to clear; a new event wins
  always_comb begin
    nxt_evt_status = evt_status_ff;
    if (wr_hit(i_bus, `DICFG_OFS_EVT_STATUS)) begin
      nxt_evt_status = evt_status_ff & ~i_bus.wdata[2:0];
    end
    nxt_evt_status = nxt_evt_status | nxt_latch_evt;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      evt_status_ff <= `DICFG_VEC_RST;
    end else begin
      evt_status_ff <= nxt_evt_status;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      evt_mask_ff <= `DICFG_VEC_RST;
    end else if (wr_hit(i_bus, `DICFG_OFS_EVT_MASK)) begin
      evt_mask_ff <= i_bus.wdata[2:0];
    end
  end

  // registered output costs one cycle of interrupt latency
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(evt_status_ff & evt_mask_ff);
    end
  end

  // read mux; data valid only in the cycle after the read strobe
  always_comb begin
    nxt_rdata = `DICFG_DATA_ZERO;
    if (i_bus.rd) begin
      case (i_bus.addr)
        `DICFG_OFS_IN8_POL:    nxt_rdata = input8_polarity_setting_ff;
        `DICFG_OFS_IN8_FUNC:   nxt_rdata = input8_function_setting_ff;
        `DICFG_OFS_IN9_POL:    nxt_rdata = input9_polarity_setting_ff;
        `DICFG_OFS_IN9_FUNC:   nxt_rdata = input9_function_setting_ff;
        `DICFG_OFS_IN10_POL:   nxt_rdata = input10_polarity_setting_ff;
        `DICFG_OFS_IN10_FUNC:  nxt_rdata = input10_function_setting_ff;
        `DICFG_OFS_EVT_STATUS: nxt_rdata = {13'h0000, evt_status_ff};
        `DICFG_OFS_EVT_MASK:   nxt_rdata = {13'h0000, evt_mask_ff};
        `DICFG_OFS_LEVEL:      nxt_rdata = {13'h0000, level_ff};
        default:               nxt_rdata = `DICFG_DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rdata_ff <= `DICFG_DATA_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata     = rdata_ff;
  assign o_din_level = level_ff;
  assign o_latch_evt = latch_evt_ff;
  assign o_irq       = irq_ff;

endmodule

/* File: rtl/dicfg_map.svh */
// register offsets, field positions and reset values of the input block
`ifndef DICFG_MAP_SVH
`define DICFG_MAP_SVH

`define DICFG_ADDR_W          8
`define DICFG_DATA_W          16
`define DICFG_NUM_LINES       3
`define DICFG_DIGIT_W         4

// word offsets on the register port
`define DICFG_OFS_IN8_POL     8'h00
`define DICFG_OFS_IN8_FUNC    8'h01
`define DICFG_OFS_IN9_POL     8'h02
`define DICFG_OFS_IN9_FUNC    8'h03
`define DICFG_OFS_IN10_POL    8'h04
`define DICFG_OFS_IN10_FUNC   8'h05
`define DICFG_OFS_EVT_STATUS  8'h06
`define DICFG_OFS_EVT_MASK    8'h07
`define DICFG_OFS_LEVEL       8'h08

// lowest bit of each setting digit
`define DICFG_POL_LSB         0
`define DICFG_FUNC_LSB        0
`define DICFG_EDGE_LSB        4

// line index of each input inside the per-line vectors
`define DICFG_IDX_IN8         0
`define DICFG_IDX_IN9         1
`define DICFG_IDX_IN10        2

`define DICFG_CFG_RST         16'h0000
`define DICFG_VEC_RST         3'h0
`define DICFG_DATA_ZERO       16'h0000

`endif

/* File: rtl/dicfg_pkg.sv */
// types shared by the digital input configuration block
package dicfg_pkg;
  `include "dicfg_map.svh"

  // one register port request, all fields sampled together
  typedef struct packed {
    logic [`DICFG_ADDR_W-1:0] addr;
    logic [`DICFG_DATA_W-1:0] wdata;
    logic                     wr;
    logic                     rd;
  } dicfg_bus_req_t;

  typedef enum logic {
    DICFG_FUNC_DIGITAL,
    DICFG_FUNC_LATCH
  } dicfg_func_t;

  typedef enum logic {
    DICFG_EDGE_RISE,
    DICFG_EDGE_FALL
  } dicfg_edge_t;

  // decoded settings of one input line
  typedef struct packed {
    logic        invert;
    dicfg_func_t func;
    dicfg_edge_t edge_sel;
  } dicfg_line_cfg_t;
endpackage

/* File: test/dicfg_assertions.sv */
// port-level assertions of the input block
`timescale 1ns/100ps
module dicfg_chk (
  input wire logic                      i_ref_clk,
  input wire logic                      i_sys_rst,
  input wire dicfg_pkg::dicfg_bus_req_t i_bus,
  input wire logic [2:0]                i_din_pins,
  input wire logic [15:0]               o_rdata,
  input wire logic [2:0]                o_din_level,
  input wire logic [2:0]                o_latch_evt,
  input wire logic                      o_irq
);
  logic [2:0] age_ff;
  wire        ok = age_ff == 3'h7;
  // synchroniser flush after reset may pulse once on a high pin
  always_ff @(posedge i_ref_clk)
    if (i_sys_rst) age_ff <= 3'h0;
    else if (!ok) age_ff <= age_ff + 3'h1;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence quiet_s;
    (!i_bus.wr && $stable(i_din_pins) && ok) [*4];
  endsequence
  AST_EVT_CAUSE: assert property (ok |-> (o_latch_evt &
    ~($past(i_din_pins, 3) ^ $past(i_din_pins, 4))) == 3'h0)
    else $error("event without pin change");
  AST_EVT_ONE: assert property (
    (o_latch_evt & $past(o_latch_evt)) == 3'h0)
    else $error("event longer than a cycle");
  AST_ROLE_EXCL: assert property ((o_din_level & o_latch_evt) == 3'h0)
    else $error("line has level and event");
  AST_LEVEL_HOLD: assert property (quiet_s |-> $stable(o_din_level)
    && o_latch_evt == 3'h0) else $error("level moved on quiet pins");
  AST_IRQ_RISE: assert property ($rose(o_irq) |->
    $past(|o_latch_evt) || $past(i_bus.wr, 2))
    else $error("irq rose without cause");
  AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(i_bus.wr, 2))
    else $error("irq fell without write");
  AST_RD_IDLE: assert property (!$past(i_bus.rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read slot");
endmodule
bind dicfg_top dicfg_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus),
  .i_din_pins(i_din_pins), .o_rdata(o_rdata),
  .o_din_level(o_din_level), .o_latch_evt(o_latch_evt), .o_irq(o_irq));

/* File: test/dicfg_field.sv */
// field side model driving the three input pins
`timescale 1ns/100ps
module dicfg_field (
  input  wire logic       i_ref_clk,
  input  wire logic [2:0] i_lvl,
  output logic      [2:0] o_pins
);
  // pins move just after an edge, never on it
  initial o_pins = 3'h0;
  always @(posedge i_ref_clk) o_pins <= i_lvl;
endmodule

/* File: test/testbench.sv */
// self-checking bench of the digital input block
`timescale 1ns/100ps
module testbench;
  logic                      clk = 1'h0;
  logic                      rst = 1'h1;
  dicfg_pkg::dicfg_bus_req_t bus = '0;
  logic [2:0]                lvl = 3'h0;
  logic [2:0]                pins;
  logic [15:0]               rdata;
  logic [2:0]                level;
  logic [2:0]                evt;
  logic                      irq;
  int                        error_cnt = 0;
  int                        check_count = 0;
  int                        ev_cnt [3] = '{0, 0, 0};
  always #5 clk = ~clk;
  dicfg_field i_field (.i_ref_clk(clk), .i_lvl(lvl), .o_pins(pins));
  dicfg_top i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_bus(bus),
    .i_din_pins(pins), .o_rdata(rdata), .o_din_level(level),
    .o_latch_evt(evt), .o_irq(irq));
  always @(posedge clk)
    for (int i = 0; i < 3; i++) if (evt[i]) ev_cnt[i]++;
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    bus <= '0;
    #1 chk("rdata", exp, rdata);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset();
    for (int a = 0; a < 10; a++) rd(8'(a), 16'h0000);
    wr(8'h09, 16'hFFFF);
    rd(8'h09, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_digital();
    @(posedge clk) lvl <= 3'h5;
    wr(8'h02, 16'h0001);
    for (int a = 0; a < 6; a++)
      rd(8'(a), (a == 2) ? 16'h0001 : 16'h0000);
    rd(8'h08, 16'h0007);
    chk("level", 16'h0007, {13'h0, level});
    wr(8'h02, 16'h0000);
    repeat (3) @(posedge clk);
    rd(8'h08, 16'h0005);
    @(posedge clk) lvl <= 3'h0;
    repeat (6) @(posedge clk);
    chk("events", 16'h0000, 16'(ev_cnt[0] + ev_cnt[1] + ev_cnt[2]));
    $display("test digital done");
  endtask
  // inverted runs keep the mask off, so masking is seen too
  task automatic t_latch(input int ln, input logic eg, input logic inv);
    logic [15:0] m;
    logic        first;
    m = 16'h0001 << ln;
    first = (eg == inv);
    wr(8'(2 * ln), {15'h0, inv});
    wr(8'(2 * ln + 1), {11'h0, eg, 4'h1});
    wr(8'h07, inv ? 16'h0000 : 16'h0007);
    repeat (6) @(posedge clk);
    wr(8'h06, 16'h0007);
    ev_cnt = '{0, 0, 0};
    @(posedge clk) lvl <= m[2:0];
    repeat (6) @(posedge clk);
    rd(8'h06, first ? m : 16'h0000);
    rd(8'h08, 16'h0000);
    chk("irq", 16'(first && !inv), 16'(irq));
    wr(8'h06, 16'h0007);
    repeat (2) @(posedge clk);
    // look once the edge has settled, not in its own time step
    #1 chk("irq", 16'h0000, 16'(irq));
    @(posedge clk) lvl <= 3'h0;
    repeat (6) @(posedge clk);
    #1 chk("evt line", 16'h0001, 16'(ev_cnt[ln]));
    chk("evt other", 16'h0000, 16'(ev_cnt[(ln + 1) % 3]));
    chk("evt other", 16'h0000, 16'(ev_cnt[(ln + 2) % 3]));
    rd(8'h06, first ? 16'h0000 : m);
    wr(8'(2 * ln), 16'h0000);
    wr(8'(2 * ln + 1), 16'h0000);
    $display("test latch %0d %0d %0d done", ln, eg, inv);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_digital();
    for (int ln = 0; ln < 3; ln++)
      for (int k = 0; k < 4; k++)
        t_latch(ln, k[1], k[0]);
    finish_test();
  end
  // twelve latch runs need well under a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
endmodule
